// ===== rtl/ppt_port.sv
// Parallel port timing, address, pin enable and slave buffer status.
// Assumes an AHB-Lite master, host pins asynchronous to clk.
//
// Functional notes
// - Strobe lasts strobe_wait_count plus one cycles
// - Write hold lasts hold_wait_count plus one cycles
// - Read hold lasts hold_wait_count cycles
// - Zero strobe code forces fixed setup, hold
// - Chip select bit excluded from stepping
// - Address bit fourteen drives chip select
// - Eleven-bit address driven in master cycles
// - Pin fourteen enable hands pin to port
// - Pins ten to two enabled per bit
// - Pins one, zero: address, or pin one low and pin zero latch strobe
// - Buffer status tracks slave modes only
// - Input all-full summary over all buffers
// - Host write to full sets sticky overflow
// - Per-buffer full, cleared on software read
// - Output all-empty summary over all buffers
// - Host read of empty sets sticky underflow
// - Per-buffer empty, cleared on software write
// - Unimplemented bits read zero, writes ignored
// - Setup lasts setup_wait_count plus one cycles
// - Two-bit field selects slave or master modes
// - Master cycle optionally steps the address
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module ppt_port (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic [14:0]      pa_out,
   output logic [14:0]      pa_oe,
   input  wire logic [7:0]  pd_in,
   output logic [7:0]       pd_out,
   output logic             pd_oe,
   output logic             strb_rd,
   output logic             strb_wr,
   input  wire logic        hst_cs,
   input  wire logic        hst_rd,
   input  wire logic        hst_wr,
   input  wire logic [1:0]  hst_addr
);
   typedef struct packed {
      logic [1:0]       interrupt_request_mode;
      logic [1:0]       address_step_mode;
      logic [1:0]       mode;
      logic [1:0]       setup_wait_count;
      logic [3:0]       strobe_wait_count;
      logic [1:0]       hold_wait_count;
      logic [1:0]       address_data_multiplex_field;
      logic [1:0]       select_function_field;
      logic [14:0]      addr;
      logic [14:0]      address_pin_enables;
      logic [3:0]       in_full;
      logic             ovf;
      logic [3:0]       out_empty;
      logic             unf;
      logic [3:0][7:0]  in_buf;
      logic [3:0][7:0]  out_buf;
      logic [7:0]       mdata;
      logic             start;
      logic             cyc_rd;
      logic             wr_pend;
      logic             rd_pend;
      logic [7:0]       a_off;
      logic [31:0]      rdata;
      logic [2:0]       wr_s;
      logic [2:0]       rd_s;
      logic [1:0]       cs_s;
      logic [1:0]       ad_s1;
      logic [1:0]       ad_s2;
      logic [7:0]       din_s1;
      logic [7:0]       din_s2;
   } ppt_top_state_t;

   ppt_top_state_t      s_r;
   ppt_top_state_t      s_nxt;
   ppt_pkg::ppt_phase_t phase;
   logic                busy;
   logic                done;
   logic                mst;
   logic                slv;
   logic                muxed;
   logic                host_wr;
   logic                host_rd;
   logic [1:0]          hidx;
   logic                take;
   logic                is_buf;
   logic [1:0]          bidx;
   logic [9:0]          step;
   logic [31:0]         rv;

   // ----------------------------------------
   // Mode decode and host event detection
   // ----------------------------------------
   assign mst   = s_r.mode[1];
   assign slv   = !s_r.mode[1];
   assign muxed = s_r.address_data_multiplex_field != ppt_pkg::ADDRESS_DATA_MULTIPLEX_FIELD_NONE;
   // Edges read only the second and third sync stages
   assign host_wr = s_r.wr_s[1] & !s_r.wr_s[2] & s_r.cs_s[1] & slv;
   assign host_rd = s_r.rd_s[1] & !s_r.rd_s[2] & s_r.cs_s[1] & slv;
   // Legacy slave has a single buffer, enhanced is addressed
   assign hidx = (s_r.mode == ppt_pkg::MODE_ENH) ? s_r.ad_s2 : 2'h0;
   assign take = hsel & hready & htrans[1] & (hsize == 3'h2);
   assign is_buf = s_r.a_off[7:4] == ppt_pkg::OFF_BUF
                   && s_r.a_off[1:0] == 2'h0;
   assign bidx = s_r.a_off[3:2];

   ppt_cycle_timer u_timer (
      .clk         (clk),
      .rst         (rst),
      .start       (s_r.start),
      .is_read     (s_r.cyc_rd),
      .setup_code  (s_r.setup_wait_count),
      .strobe_code (s_r.strobe_wait_count),
      .hold_code   (s_r.hold_wait_count),
      .phase       (phase),
      .busy        (busy),
      .done        (done)
   );

   // ----------------------------------------
   // Register read view
   // ----------------------------------------
   always_comb
   begin
      rv = 32'h0000_0000;
      case (s_r.a_off)
         ppt_pkg::OFF_MODE:
            rv = (32'(busy | s_r.start) << ppt_pkg::MODE_BUSY)
               | (32'(s_r.interrupt_request_mode)  << ppt_pkg::MODE_INTERRUPT_REQUEST_MODE)
               | (32'(s_r.address_step_mode)  << ppt_pkg::MODE_ADDRESS_STEP_MODE)
               | (32'(s_r.mode)  << ppt_pkg::MODE_SEL)
               | (32'(s_r.setup_wait_count) << ppt_pkg::MODE_SETUP_WAIT_COUNT)
               | (32'(s_r.strobe_wait_count) << ppt_pkg::MODE_STROBE_WAIT_COUNT)
               | (32'(s_r.hold_wait_count) << ppt_pkg::MODE_HOLD_WAIT_COUNT);
         ppt_pkg::OFF_CFG:
            rv = (32'(s_r.address_data_multiplex_field) << ppt_pkg::CFG_ADDRESS_DATA_MULTIPLEX_FIELD)
               | (32'(s_r.select_function_field)    << ppt_pkg::CFG_CSF);
         ppt_pkg::OFF_ADDR:
            rv = 32'(s_r.addr);
         ppt_pkg::OFF_PINEN:
            rv = 32'(s_r.address_pin_enables);
         ppt_pkg::OFF_STAT:
            rv = (32'(&s_r.in_full)   << ppt_pkg::STAT_IBF)
               | (32'(s_r.ovf)        << ppt_pkg::STAT_INPUT_OVERFLOW_FLAG)
               | (32'(s_r.in_full)    << ppt_pkg::STAT_INPUT_BUFFER_FULL_FLAGS)
               | (32'(&s_r.out_empty) << ppt_pkg::STAT_OBE)
               | (32'(s_r.unf)        << ppt_pkg::STAT_OUTPUT_UNDERFLOW_FLAG)
               | (32'(s_r.out_empty)  << ppt_pkg::STAT_OUTPUT_BUFFER_EMPTY_FLAGS);
         ppt_pkg::OFF_DATA:
            rv = 32'(s_r.mdata);
         default:
            if (is_buf)
               rv = 32'(s_r.in_buf[bidx]);
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.start   = 1'b0;
      s_nxt.wr_s    = {s_r.wr_s[1:0], hst_wr};
      s_nxt.rd_s    = {s_r.rd_s[1:0], hst_rd};
      s_nxt.cs_s    = {s_r.cs_s[0], hst_cs};
      s_nxt.ad_s1   = hst_addr;
      s_nxt.ad_s2   = s_r.ad_s1;
      s_nxt.din_s1  = pd_in;
      s_nxt.din_s2  = s_r.din_s1;
      s_nxt.wr_pend = take & hwrite;
      s_nxt.rd_pend = take & !hwrite;
      if (take)
         s_nxt.a_off = haddr[7:0];
      // Address stepping of the combined field
      if (s_r.select_function_field == ppt_pkg::CSF_CS)
         step = {1'b0, s_r.addr[10:2]};
      else
         step = {s_r.addr[14], s_r.addr[10:2]};
      if (s_r.address_step_mode == ppt_pkg::ADDRESS_STEP_MODE_INC)
         step = step + 10'h001;
      else if (s_r.address_step_mode == ppt_pkg::ADDRESS_STEP_MODE_DEC)
         step = step - 10'h001;
      if (s_r.wr_pend)
      begin
         case (s_r.a_off)
            ppt_pkg::OFF_MODE:
               // Timing changes mid-cycle would tear a strobe
               if (!busy && !s_r.start)
               begin
                  s_nxt.interrupt_request_mode  = hwdata[ppt_pkg::MODE_INTERRUPT_REQUEST_MODE +: 2];
                  s_nxt.address_step_mode  = hwdata[ppt_pkg::MODE_ADDRESS_STEP_MODE +: 2];
                  s_nxt.mode  = hwdata[ppt_pkg::MODE_SEL +: 2];
                  s_nxt.setup_wait_count = hwdata[ppt_pkg::MODE_SETUP_WAIT_COUNT +: 2];
                  s_nxt.strobe_wait_count = hwdata[ppt_pkg::MODE_STROBE_WAIT_COUNT +: 4];
                  s_nxt.hold_wait_count = hwdata[ppt_pkg::MODE_HOLD_WAIT_COUNT +: 2];
               end
            ppt_pkg::OFF_CFG:
            begin
               s_nxt.address_data_multiplex_field = hwdata[ppt_pkg::CFG_ADDRESS_DATA_MULTIPLEX_FIELD +: 2];
               s_nxt.select_function_field    = hwdata[ppt_pkg::CFG_CSF +: 2];
            end
            ppt_pkg::OFF_ADDR:
               s_nxt.addr = hwdata[14:0] & ppt_pkg::ADDR_MASK;
            ppt_pkg::OFF_PINEN:
               s_nxt.address_pin_enables = hwdata[14:0] & ppt_pkg::ADDR_MASK;
            ppt_pkg::OFF_STAT:
            begin
               s_nxt.ovf = hwdata[ppt_pkg::STAT_INPUT_OVERFLOW_FLAG];
               s_nxt.unf = hwdata[ppt_pkg::STAT_OUTPUT_UNDERFLOW_FLAG];
            end
            ppt_pkg::OFF_DATA:
               if (mst && !busy && !s_r.start)
               begin
                  s_nxt.mdata  = hwdata[7:0];
                  s_nxt.start  = 1'b1;
                  s_nxt.cyc_rd = 1'b0;
               end
            default:
               if (is_buf)
               begin
                  s_nxt.out_buf[bidx]   = hwdata[7:0];
                  s_nxt.out_empty[bidx] = 1'b0;
               end
         endcase
      end
      if (s_r.rd_pend)
      begin
         s_nxt.rdata = rv;
         // Reading data returns the last byte and fetches the next
         if (s_r.a_off == ppt_pkg::OFF_DATA && mst && !busy
             && !s_r.start)
         begin
            s_nxt.start  = 1'b1;
            s_nxt.cyc_rd = 1'b1;
         end
         else if (is_buf)
            s_nxt.in_full[bidx] = 1'b0;
      end
      // Sample while the strobe stands; the bus is released in hold
      if (phase == ppt_pkg::PH_STROBE && s_r.cyc_rd)
         s_nxt.mdata = s_r.din_s2;
      if (done)
      begin
         if (s_r.address_step_mode == ppt_pkg::ADDRESS_STEP_MODE_INC
             || s_r.address_step_mode == ppt_pkg::ADDRESS_STEP_MODE_DEC)
         begin
            s_nxt.addr[10:2] = step[8:0];
            if (s_r.select_function_field != ppt_pkg::CSF_CS)
               s_nxt.addr[14] = step[9];
         end
      end
      // Hardware events last so a set beats a same-cycle clear
      if (host_wr)
      begin
         if (s_r.in_full[hidx])
            s_nxt.ovf = 1'b1;
         else
         begin
            s_nxt.in_buf[hidx]  = s_r.din_s2;
            s_nxt.in_full[hidx] = 1'b1;
         end
      end
      if (host_rd)
      begin
         if (s_r.out_empty[hidx])
            s_nxt.unf = 1'b1;
         else
            s_nxt.out_empty[hidx] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r           <= '0;
         s_r.out_empty <= ppt_pkg::OUTPUT_BUFFER_EMPTY_FLAGS_RST;
         s_r.addr      <= ppt_pkg::ADDR_RST;
         s_r.address_pin_enables      <= ppt_pkg::PINEN_RST;
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   // One wait state on reads keeps read side effects exact
   assign hreadyout = !s_r.rd_pend;
   assign hrdata    = s_r.rdata;
   assign hresp     = 1'b0;

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   for (genvar g = 2; g <= 10; g++)
   begin : g_apin
      assign pa_out[g] = s_r.addr[g];
      assign pa_oe[g]  = s_r.address_pin_enables[g] & mst;
   end
   assign pa_out[13:11] = 3'h0;
   assign pa_oe[13:11]  = 3'h0;
   // Same bit serves as chip select or address line fourteen
   assign pa_out[14] = s_r.addr[ppt_pkg::ADDR_CS];
   assign pa_oe[14]  = s_r.address_pin_enables[14] & mst;
   // High latch strobe on pin zero marks the address phase when multiplexed
   assign pa_out[0] = muxed ? (phase == ppt_pkg::PH_SETUP)
                            : s_r.addr[0];
   assign pa_out[1] = muxed ? 1'b0 : s_r.addr[1];
   assign pa_oe[1:0] = s_r.address_pin_enables[1:0] & {2{mst}};
   assign pd_out = !mst ? s_r.out_buf[hidx]
                 : (muxed && phase == ppt_pkg::PH_SETUP)
                 ? s_r.addr[7:0] : s_r.mdata;
   assign pd_oe = mst ? ((busy & !s_r.cyc_rd)
                         | (muxed && phase == ppt_pkg::PH_SETUP))
                      : (s_r.rd_s[1] & s_r.cs_s[1]);
   assign strb_rd = !mst ? 1'b0
                  : (s_r.mode == ppt_pkg::MODE_MAS1)
                  ? (busy & s_r.cyc_rd)
                  : (phase == ppt_pkg::PH_STROBE && s_r.cyc_rd);
   assign strb_wr = !mst ? 1'b0
                  : (s_r.mode == ppt_pkg::MODE_MAS1)
                  ? (phase == ppt_pkg::PH_STROBE)
                  : (phase == ppt_pkg::PH_STROBE && !s_r.cyc_rd);

   a_ovf_sticky: assert property (
      @(posedge clk) disable iff (rst)
      s_r.ovf && !(s_r.wr_pend && s_r.a_off == ppt_pkg::OFF_STAT)
      |=> s_r.ovf)
      else $error("overflow flag lost");
   a_full_set: assert property (
      @(posedge clk) disable iff (rst)
      host_wr && !s_r.in_full[hidx]
      |=> s_r.in_full[$past(hidx)])
      else $error("input full not set");
   a_cs_kept: assert property (
      @(posedge clk) disable iff (rst)
      done && s_r.select_function_field == ppt_pkg::CSF_CS && !s_r.wr_pend
      |=> s_r.addr[14] == $past(s_r.addr[14]))
      else $error("chip select bit stepped");
   a_addr_step: assert property (
      @(posedge clk) disable iff (rst)
      done && s_r.address_step_mode == ppt_pkg::ADDRESS_STEP_MODE_INC && !s_r.wr_pend
      && s_r.addr[10:2] != 9'h1FF
      |=> s_r.addr[10:2] == $past(s_r.addr[10:2]) + 9'h001)
      else $error("address not incremented");
   a_rsv_zero: assert property (
      @(posedge clk) disable iff (rst)
      hrdata[31:16] == 16'h0000 && s_r.addr[13:11] == 3'h0)
      else $error("reserved bits not zero");
   a_slave_quiet: assert property (
      @(posedge clk) disable iff (rst)
      mst |-> !(host_wr || host_rd))
      else $error("host event in master mode");
endmodule // ppt_port

// ===== rtl/ppt_pkg.sv
// Constants, offsets, field positions and phase type of the port block.
// Assumes a 32-bit AHB-Lite slave decoded on the low eight address bits.
package ppt_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_MODE  = 8'h00;
   localparam logic [7:0] OFF_CFG   = 8'h04;
   localparam logic [7:0] OFF_ADDR  = 8'h08;
   localparam logic [7:0] OFF_PINEN = 8'h0C;
   localparam logic [7:0] OFF_STAT  = 8'h10;
   localparam logic [7:0] OFF_DATA  = 8'h14;
   localparam logic [3:0] OFF_BUF   = 4'h2;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MODE_BUSY  = 15;
   localparam int MODE_INTERRUPT_REQUEST_MODE  = 13;
   localparam int MODE_ADDRESS_STEP_MODE  = 11;
   localparam int MODE_SEL   = 8;
   localparam int MODE_SETUP_WAIT_COUNT = 6;
   localparam int MODE_STROBE_WAIT_COUNT = 2;
   localparam int MODE_HOLD_WAIT_COUNT = 0;
   localparam int CFG_ADDRESS_DATA_MULTIPLEX_FIELD = 11;
   localparam int CFG_CSF    = 6;
   localparam int ADDR_CS    = 14;
   localparam int STAT_IBF   = 15;
   localparam int STAT_INPUT_OVERFLOW_FLAG  = 14;
   localparam int STAT_INPUT_BUFFER_FULL_FLAGS  = 8;
   localparam int STAT_OBE   = 7;
   localparam int STAT_OUTPUT_UNDERFLOW_FLAG  = 6;
   localparam int STAT_OUTPUT_BUFFER_EMPTY_FLAGS  = 0;
   // ----------------------------------------
   // Masks and reset values
   // ----------------------------------------
   localparam logic [14:0] ADDR_MASK  = 15'h47FF;
   localparam logic [14:0] ADDR_RST   = 15'h0000;
   localparam logic [14:0] PINEN_RST  = 15'h0000;
   localparam logic [3:0]  OUTPUT_BUFFER_EMPTY_FLAGS_RST   = 4'hF;
   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam logic [1:0] MODE_LEGACY = 2'h0;
   localparam logic [1:0] MODE_ENH    = 2'h1;
   localparam logic [1:0] MODE_MAS2   = 2'h2;
   localparam logic [1:0] MODE_MAS1   = 2'h3;
   localparam logic [1:0] ADDRESS_STEP_MODE_INC    = 2'h1;
   localparam logic [1:0] ADDRESS_STEP_MODE_DEC    = 2'h2;
   localparam logic [1:0] CSF_CS      = 2'h2;
   localparam logic [1:0] ADDRESS_DATA_MULTIPLEX_FIELD_NONE = 2'h0;
   // ----------------------------------------
   // Timing in peripheral clock cycles
   // ----------------------------------------
   localparam logic [3:0] STROBE_WAIT_COUNT_FAST    = 4'h0;
   localparam logic [3:0] FAST_SETUP_CYC = 4'h1;
   localparam logic [2:0] FAST_WR_HOLD  = 3'h1;
   localparam logic [2:0] FAST_RD_HOLD  = 3'h0;
   typedef enum logic [1:0] {
      PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD
   } ppt_phase_t;
endpackage

// ===== rtl/ppt_cycle_timer.sv
// Master cycle sequencer: setup, strobe and hold phases.
// Assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/1ns
module ppt_cycle_timer (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               start,
   input  wire logic               is_read,
   input  wire logic [1:0]         setup_code,
   input  wire logic [3:0]         strobe_code,
   input  wire logic [1:0]         hold_code,
   output ppt_pkg::ppt_phase_t     phase,
   output logic                    busy,
   output logic                    done
);
   typedef struct packed {
      ppt_pkg::ppt_phase_t ph;
      logic [3:0]          cnt;
      logic [3:0]          sc;
      logic [1:0]          hc;
      logic                rd;
      logic                fast;
   } ppt_tmr_state_t;

   ppt_tmr_state_t s_r;
   ppt_tmr_state_t s_nxt;
   logic [2:0]     hold_len;

   // ----------------------------------------
   // Phase sequencing
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      done  = 1'b0;
      // Fast timing forces one setup and a fixed hold
      if (s_r.fast)
         hold_len = s_r.rd ? ppt_pkg::FAST_RD_HOLD
                           : ppt_pkg::FAST_WR_HOLD;
      else if (s_r.rd)
         hold_len = {1'b0, s_r.hc};
      else
         hold_len = {1'b0, s_r.hc} + 3'h1;
      case (s_r.ph)
         ppt_pkg::PH_IDLE:
            if (start)
            begin
               s_nxt.ph   = ppt_pkg::PH_SETUP;
               s_nxt.rd   = is_read;
               s_nxt.sc   = strobe_code;
               s_nxt.hc   = hold_code;
               s_nxt.fast = strobe_code == ppt_pkg::STROBE_WAIT_COUNT_FAST;
               if (strobe_code == ppt_pkg::STROBE_WAIT_COUNT_FAST)
                  s_nxt.cnt = ppt_pkg::FAST_SETUP_CYC - 4'h1;
               else
                  s_nxt.cnt = {2'h0, setup_code};
            end
         ppt_pkg::PH_SETUP:
            if (s_r.cnt == 4'h0)
            begin
               s_nxt.ph  = ppt_pkg::PH_STROBE;
               s_nxt.cnt = s_r.sc;
            end
            else
               s_nxt.cnt = s_r.cnt - 4'h1;
         ppt_pkg::PH_STROBE:
            if (s_r.cnt != 4'h0)
               s_nxt.cnt = s_r.cnt - 4'h1;
            else if (hold_len == 3'h0)
            begin
               s_nxt.ph = ppt_pkg::PH_IDLE;
               done     = 1'b1;
            end
            else
            begin
               s_nxt.ph  = ppt_pkg::PH_HOLD;
               s_nxt.cnt = {1'b0, hold_len - 3'h1};
            end
         ppt_pkg::PH_HOLD:
            if (s_r.cnt == 4'h0)
            begin
               s_nxt.ph = ppt_pkg::PH_IDLE;
               done     = 1'b1;
            end
            else
               s_nxt.cnt = s_r.cnt - 4'h1;
         default:
            s_nxt.ph = ppt_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign phase = s_r.ph;
   assign busy  = s_r.ph != ppt_pkg::PH_IDLE;

   a_strobe_entry: assert property (
      @(posedge clk) disable iff (rst)
      s_r.ph == ppt_pkg::PH_SETUP && s_r.cnt == 4'h0
      |=> s_r.ph == ppt_pkg::PH_STROBE && s_r.cnt == $past(s_r.sc))
      else $error("strobe count not loaded");
   a_strobe_count: assert property (
      @(posedge clk) disable iff (rst)
      s_r.ph == ppt_pkg::PH_STROBE && s_r.cnt != 4'h0
      |=> s_r.ph == ppt_pkg::PH_STROBE
          && s_r.cnt == $past(s_r.cnt) - 4'h1)
      else $error("strobe ended early");
   a_write_hold: assert property (
      @(posedge clk) disable iff (rst)
      s_r.ph == ppt_pkg::PH_STROBE && s_r.cnt == 4'h0 && !s_r.rd
      |=> s_r.ph == ppt_pkg::PH_HOLD
          && s_r.cnt == ($past(s_r.fast) ? 4'h0 : {2'h0, $past(s_r.hc)}))
      else $error("write hold length wrong");
   a_fast_read: assert property (
      @(posedge clk) disable iff (rst)
      s_r.ph == ppt_pkg::PH_STROBE && s_r.cnt == 4'h0
      && s_r.rd && s_r.fast |-> done ##1 !busy)
      else $error("fast read has hold phase");
   a_busy_order: assert property (
      @(posedge clk) disable iff (rst)
      start && !busy |=> s_r.ph == ppt_pkg::PH_SETUP)
      else $error("cycle did not begin with setup");
endmodule // ppt_cycle_timer

// ===== sim/ppt_ext_model.sv
// External peripheral and host model facing the port pins.
// Assumes the bench calls host() just after a rising clk edge.
`timescale 1ns/1ns
module ppt_ext_model (
   input  wire logic       clk,
   input  wire logic       strb_rd,
   input  wire logic [7:0] rd_byte,
   output logic [7:0]      pd_in,
   output logic            hst_cs,
   output logic            hst_rd,
   output logic            hst_wr,
   output logic [1:0]      hst_addr
);
   logic       hd = 1'b0;
   logic [7:0] hb = 8'h00;
   initial
   begin
      {hst_cs, hst_rd, hst_wr, hst_addr, pd_in} = 13'h0000;
   end
   // Released bus toggles so a stale byte never passes for data
   always @(posedge clk)
      pd_in <= hd ? hb : (strb_rd ? rd_byte : ~pd_in);
   // Host strobes are slow against clk; overrun and underrun on demand
   task host(input logic wr, input logic [1:0] a, input logic [7:0] d);
      hst_cs   <= 1'b1;
      hst_addr <= a;
      hb       <= d;
      hd       <= wr;
      repeat (3) @(posedge clk);
      hst_wr   <= wr;
      hst_rd   <= !wr;
      repeat (4) @(posedge clk);
      {hst_wr, hst_rd} <= 2'h0;
      repeat (4) @(posedge clk);
      hst_cs   <= 1'b0;
      hd       <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule // ppt_ext_model

// ===== sim/testbench.sv
// Self-checking bench for the parallel port block.
// Assumes the port is the only AHB-Lite slave on the bus.
`timescale 1ns/1ns
module testbench;
   logic        clk, rst, hsel, hwrite, hreadyout, hresp, pd_oe;
   logic        strb_rd, strb_wr, hst_cs, hst_rd, hst_wr, wr, m11;
   logic [1:0]  htrans, hst_addr, b, e;
   logic [2:0]  hsize;
   logic [3:0]  m;
   logic [31:0] haddr, hwdata, hrdata, q, r, seed = 32'd70783;
   logic [14:0] pa_out, pa_oe, pa_cap, a;
   logic [7:0]  pd_in, pd_out, rb;
   int          miscompares, num_checks, n_wr, n_rd, n_oe;
   ppt_port ppt_port_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .pa_out, .pa_oe, .pd_in, .pd_out, .pd_oe, .strb_rd, .strb_wr,
      .hst_cs, .hst_rd, .hst_wr, .hst_addr);
   ppt_ext_model ppt_ext_model_inst (.clk, .strb_rd, .rd_byte(rb), .pd_in,
      .hst_cs, .hst_rd, .hst_wr, .hst_addr);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pins are counted at the falling edge, where they are settled
   always @(negedge clk)
   begin
      n_wr += strb_wr;
      n_rd += strb_rd;
      n_oe += pd_oe;
      if (strb_wr | strb_rd) pa_cap = pa_out;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic int mlen(input logic rd, input logic [1:0] b,
      input logic [3:0] m, input logic [1:0] e);
      if (m == 4'h0) return rd ? 2 : 3;
      return b + m + e + (rd ? 2 : 3);
   endfunction
   function automatic logic [14:0] step(input logic [14:0] a, input logic c);
      logic [9:0] s;
      s = c ? {a[14], a[10:2] + 9'h001} : {a[14], a[10:2]} + 10'h001;
      return {s[9], 3'h0, s[8:0], a[1:0]};
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] x, input string s);
      num_checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h want %h", $time, s, g, x);
      end
   endtask
   task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, ad};
      hwrite <= w;
      do @(negedge clk); while (hreadyout !== 1'b1);
      @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      do @(negedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge clk);
   endtask
   task poll;
      repeat (40)
      begin
         ahb(1'b0, ppt_pkg::OFF_MODE, 32'h0);
         if (q[15] === 1'b0) break;
      end
      chk(q[15], 1'b0, "busy stuck");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #2000000;
      miscompares++;
      wrap_up;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {rst, hsel, hwrite, htrans, haddr, hwdata, rb} = {1'b1, 76'h0};
      hsize = 3'h2;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(1'b0, ppt_pkg::OFF_STAT, 32'h0);
      chk(q, 32'h8F, "status reset");
      ahb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0, "unmapped");
      ahb(1'b1, ppt_pkg::OFF_ADDR, 32'hFFFFFFFF);
      ahb(1'b0, ppt_pkg::OFF_ADDR, 32'h0);
      chk(q, 32'h47FF, "addr bits");
      ahb(1'b1, ppt_pkg::OFF_PINEN, 32'hFFFFFFFF);
      ahb(1'b0, ppt_pkg::OFF_PINEN, 32'h0);
      chk(q, 32'h47FF, "pin enable bits");
      $display("register test done");
      for (int i = 0; i < 10; i++)
      begin
         seed = xs(seed);
         r = seed;
         {wr, m11, b, m, e} = r[9:0];
         if (i < 2) {m, b, e} = i ? 8'hFF : 8'h00;
         a = {4'h0, r[26:16]};
         rb = r[31:24];
         ahb(1'b1, ppt_pkg::OFF_ADDR, {17'h0, a});
         ahb(1'b1, ppt_pkg::OFF_MODE, {19'h0, 4'h5, m11, b, m, e});
         n_wr = 0;
         n_rd = 0;
         n_oe = 0;
         ahb(wr, ppt_pkg::OFF_DATA, {24'h0, r[15:8]});
         poll;
         chk(wr | m11 ? n_wr : n_rd, m + 1, "strobe");
         if (wr | m11)
            chk(wr ? n_oe : n_rd, mlen(!wr, b, m, e), "len");
         chk(pa_cap[10:0], a[10:0], "address pins");
         chk(pa_oe, 15'h47FF, "pin enables");
         ahb(1'b0, ppt_pkg::OFF_ADDR, 32'h0);
         chk(q, step(a, 1'b0), "address step");
         if (!wr & !m11 & m > 3)
         begin
            ahb(1'b0, ppt_pkg::OFF_DATA, 32'h0);
            chk(q[7:0], rb, "read byte");
            poll;
         end
      end
      ahb(1'b1, ppt_pkg::OFF_CFG, 32'h80);
      ahb(1'b1, ppt_pkg::OFF_ADDR, 32'h47FC);
      ahb(1'b1, ppt_pkg::OFF_DATA, 32'h5A);
      poll;
      chk(pa_cap[14], 1'b1, "chip select");
      ahb(1'b0, ppt_pkg::OFF_ADDR, 32'h0);
      chk(q, step(15'h47FC, 1'b1), "select kept");
      $display("master test done");
      ahb(1'b1, ppt_pkg::OFF_MODE, 32'h100);
      for (int i = 0; i < 5; i++)
         ppt_ext_model_inst.host(1'b1, i[1:0], 8'hA0);
      ahb(1'b0, ppt_pkg::OFF_STAT, 32'h0);
      chk(q, 32'hCF8F, "inputs full");
      ahb(1'b0, {ppt_pkg::OFF_BUF, 4'h0}, 32'h0);
      chk(q[7:0], 8'hA0, "buffer byte");
      ahb(1'b0, ppt_pkg::OFF_STAT, 32'h0);
      chk(q, 32'h4E8F, "overflow sticky");
      ahb(1'b1, ppt_pkg::OFF_STAT, 32'h0);
      ppt_ext_model_inst.host(1'b0, 2'h1, 8'h00);
      ahb(1'b1, {ppt_pkg::OFF_BUF, 4'h4}, 32'h33);
      ahb(1'b0, ppt_pkg::OFF_STAT, 32'h0);
      chk(q, 32'h0E4D, "output flags");
      $display("slave test done");
      wrap_up;
   end
endmodule // testbench
